// [hw/scp_consts.svh]
// Constants for the sector protection bit logic
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// ****************************************
// Opcodes
// ****************************************
`define SCP_OP_LOCK_ALL 8'h7e
`define SCP_OP_UNLOCK_ALL 8'h98

// ****************************************
// Status byte layout and read answers
// ****************************************
`define SCP_LOCK_BIT 0
`define SCP_RD_ZERO 8'h00
`define SCP_RD_ONE 8'hff
`define SCP_MODE_SOLID 2'b11

// ****************************************
// Array geometry
// ****************************************
`define SCP_SECT_SHIFT 12
`define SCP_BLK_SHIFT 16
`define SCP_EDGE_SECTS 16

`endif

// [hw/scp_pkg.sv]
// Types for the sector protection bit logic
package scp_pkg;

	// Decoded protection command
	typedef enum logic [3:0] {
		SCP_CMD_NONE = 4'h0,
		SCP_CMD_LOCK_SET = 4'h1,
		SCP_CMD_SET_SOLID = 4'h2,
		SCP_CMD_CLR_SOLID = 4'h3,
		SCP_CMD_RD_SOLID = 4'h4,
		SCP_CMD_RD_LOCK = 4'h5,
		SCP_CMD_WR_DYN = 4'h6,
		SCP_CMD_RD_DYN = 4'h7,
		SCP_CMD_LOCK_ALL = 4'h8,
		SCP_CMD_UNLOCK_ALL = 4'h9,
		SCP_CMD_PASS_OK = 4'ha
	} scp_cmd_e;

	// One command as handed over by the serial front end
	typedef struct packed {
		logic valid;
		scp_cmd_e cmd;
		logic [31:0] addr;
		logic value;
	} scp_req_s;

	// Read answer
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} scp_rsp_s;

endpackage

// [hw/scp_protect.sv]
// Per-region solid and dynamic write-protection bit logic
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.svh"

// Function
// - Volatile lock flag at status bit zero
// - First cycle after reset loads lock flag from mode bits
// - Lock-set command clears the lock flag
// - Only reset returns lock flag in solid
// - Password unlock sets flag in password mode
// - Lock status read returns flag, zeros above
// - Solid bit per edge sector, else block
// - Solid bits nonvolatile, factory zero
// - Protected unmasked region refuses program/erase
// - Set single solid bit; no single clear
// - Clear-all clears every solid bit
// - Lock flag zero ignores solid changes
// - Solid read returns 00h or FFh
// - Dynamic bit per region, same granularity
// - Dynamic one protects; zero needs solid zero
// - All dynamic bits set after reset
// - Write dynamic bit to supplied value
// - Unlock-all clears, lock-all sets dynamic
// - Dynamic read returns 00h or FFh
// - Override zero masks all solid bits
// - Gang opcodes 7Eh and 98h, single byte
// - Active only when scheme select is one
module scp_protect #(
	parameter int ADDR_W = 27,
	parameter logic [1:0] NV_RESET_BITS = 2'b00
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire scp_pkg::scp_req_s req,
	input wire logic [7:0] opcode,
	input wire logic opcode_valid,
	input wire logic write_latch,
	input wire logic protect_scheme_select,
	input wire logic [1:0] mode_lock_bits,
	input wire logic solid_override_bit,
	input wire logic [ADDR_W-1:0] check_addr,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic region_protected,
	output logic [7:0] lock_status,
	output logic write_latch_clear
);

	// ****************************************
	// Region geometry
	// ****************************************
	localparam int NBLK = 1 << (ADDR_W - `SCP_BLK_SHIFT);
	localparam int NREG = NBLK - 2 + 2 * `SCP_EDGE_SECTS;
	localparam int IW = $clog2(NREG);

	// Address to region index: edge 64KB splits into 4KB sectors
	function automatic logic [IW-1:0] region_of(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-`SCP_BLK_SHIFT-1:0] blk;
		logic [3:0] sec;
		blk = a[ADDR_W-1:`SCP_BLK_SHIFT];
		sec = a[`SCP_BLK_SHIFT-1:`SCP_SECT_SHIFT];
		if (blk == '0)
			region_of = IW'(sec);
		else if (blk == '1)
			region_of = IW'(NREG - `SCP_EDGE_SECTS) + IW'(sec);
		else
			region_of = IW'(`SCP_EDGE_SECTS - 1) + IW'(blk);
	endfunction

	// ****************************************
	// Protection state
	// ****************************************
	// Solid bits would live in nonvolatile cells; modelled as flops
	// Factory state at power-up only; a reset must not touch them
	logic [NREG-1:0] solid_reg = {NREG{NV_RESET_BITS[0]}};
	logic [NREG-1:0] solid_next;
	logic [NREG-1:0] dyn_reg, dyn_next;
	logic lock_reg, lock_next;
	logic [7:0] rd_data_reg, rd_data_next;
	logic rd_valid_reg, prot_reg, wl_clr_reg;
	logic seeded_reg;

	// Command qualification
	wire logic active = protect_scheme_select;
	wire logic solid_mode = (mode_lock_bits == `SCP_MODE_SOLID);
	wire logic [IW-1:0] req_idx = region_of(req.addr[ADDR_W-1:0]);
	wire logic [IW-1:0] chk_idx = region_of(check_addr);
	wire logic go = req.valid && active;
	wire logic wr_ok = go && write_latch;
	wire logic solid_wr = wr_ok && lock_reg;
	// Single-byte gang opcodes taken straight from the frame
	wire logic gang_lock = opcode_valid && active && write_latch &&
		opcode == `SCP_OP_LOCK_ALL;
	wire logic gang_unlock = opcode_valid && active && write_latch &&
		opcode == `SCP_OP_UNLOCK_ALL;
	wire logic do_lock_all = gang_lock ||
		(wr_ok && req.cmd == scp_pkg::SCP_CMD_LOCK_ALL);
	wire logic do_unlock_all = gang_unlock ||
		(wr_ok && req.cmd == scp_pkg::SCP_CMD_UNLOCK_ALL);
	// Masked solid bit counts only when override is one
	wire logic chk_solid = solid_reg[chk_idx] && solid_override_bit;
	wire logic chk_prot = dyn_reg[chk_idx] || chk_solid;
	// A solid change refused while locked is ignored whole
	wire logic solid_cmd = req.cmd == scp_pkg::SCP_CMD_SET_SOLID ||
		req.cmd == scp_pkg::SCP_CMD_CLR_SOLID;
	wire logic any_write = (wr_ok && req.cmd != scp_pkg::SCP_CMD_RD_SOLID &&
		req.cmd != scp_pkg::SCP_CMD_RD_DYN &&
		req.cmd != scp_pkg::SCP_CMD_RD_LOCK &&
		!(solid_cmd && !lock_reg)) || gang_lock || gang_unlock;

	// Next-state for solid bits
	always_comb begin
		solid_next = solid_reg;
		if (solid_wr && req.cmd == scp_pkg::SCP_CMD_CLR_SOLID)
			solid_next = '0;
		else if (solid_wr && req.cmd == scp_pkg::SCP_CMD_SET_SOLID)
			solid_next[req_idx] = 1'b1;
	end

	// Next-state for dynamic bits; gang commands win over single writes
	always_comb begin
		dyn_next = dyn_reg;
		if (do_lock_all)
			dyn_next = '1;
		else if (do_unlock_all)
			dyn_next = '0;
		else if (wr_ok && req.cmd == scp_pkg::SCP_CMD_WR_DYN)
			dyn_next[req_idx] = req.value;
	end

	// Lock flag: cleared by lock-set, raised only by the first cycle after reset in solid mode or by good password
	always_comb begin
		lock_next = lock_reg;
		if (!seeded_reg)
			lock_next = solid_mode;
		else if (wr_ok && req.cmd == scp_pkg::SCP_CMD_LOCK_SET)
			lock_next = 1'b0;
		else if (go && req.cmd == scp_pkg::SCP_CMD_PASS_OK && !solid_mode)
			lock_next = 1'b1;
	end

	// Read answers
	always_comb begin
		rd_data_next = rd_data_reg;
		case (req.cmd)
			scp_pkg::SCP_CMD_RD_SOLID:
				rd_data_next = solid_reg[req_idx] ? `SCP_RD_ONE
					: `SCP_RD_ZERO;
			scp_pkg::SCP_CMD_RD_DYN:
				rd_data_next = dyn_reg[req_idx] ? `SCP_RD_ONE
					: `SCP_RD_ZERO;
			scp_pkg::SCP_CMD_RD_LOCK:
				rd_data_next = {7'h00, lock_reg};
			default:
				rd_data_next = rd_data_reg;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	// Solid bits keep their value through any reset
	always_ff @(posedge core_clk) begin
		solid_reg <= solid_next;
	end

	// Mode strap is sampled one cycle after reset release, not in reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			dyn_reg <= '1;
			lock_reg <= 1'b0;
			seeded_reg <= 1'b0;
		end else begin
			dyn_reg <= dyn_next;
			lock_reg <= lock_next;
			seeded_reg <= 1'b1;
		end
	end

	// Answers and protection check output
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rd_data_reg <= `SCP_RD_ZERO;
			rd_valid_reg <= 1'b0;
			prot_reg <= 1'b1;
			wl_clr_reg <= 1'b0;
		end else begin
			rd_data_reg <= go ? rd_data_next : rd_data_reg;
			rd_valid_reg <= go && (req.cmd == scp_pkg::SCP_CMD_RD_SOLID ||
				req.cmd == scp_pkg::SCP_CMD_RD_DYN ||
				req.cmd == scp_pkg::SCP_CMD_RD_LOCK);
			prot_reg <= !active || chk_prot;
			wl_clr_reg <= any_write;
		end
	end

	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;
	assign region_protected = prot_reg;
	assign lock_status = {7'h00, lock_reg};
	assign write_latch_clear = wl_clr_reg;

endmodule
`default_nettype wire

// [tb/scp_host_model.sv]
// Host-side model that keeps the write enable latch
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic write_latch_set_cmd,
	input wire logic write_latch_clear,
	output logic write_latch
);
	// Set by the enable command, dropped once a write is taken
	// A fresh enable wins, so back-to-back writes are not lost
	always_ff @(posedge core_clk) begin
		if (rst) begin
			write_latch <= 1'b0;
		end else if (write_latch_set_cmd) begin
			write_latch <= 1'b1;
		end else if (write_latch_clear) begin
			write_latch <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [tb/scp_protect_chk.sv]
// Port assertions for the protection bit logic
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.svh"
module scp_protect_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire scp_pkg::scp_req_s req,
	input wire logic [7:0] opcode,
	input wire logic opcode_valid,
	input wire logic write_latch,
	input wire logic protect_scheme_select,
	input wire logic solid_override_bit,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire logic region_protected,
	input wire logic [7:0] lock_status,
	input wire logic write_latch_clear
);
	// Requests the block is bound to take
	wire logic go = req.valid && protect_scheme_select;
	wire logic wgo = go && write_latch;
	wire logic gang = opcode_valid && protect_scheme_select && write_latch;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_lock_reserved: assert property (lock_status[7:1] == 7'h0)
		else $error("lock byte reserved bits set");
	a_lock_read: assert property (
		go && req.cmd == scp_pkg::SCP_CMD_RD_LOCK
		|=> rd_valid && rd_data == lock_status) else $error("bad lock read");
	a_lock_set: assert property (
		wgo && req.cmd == scp_pkg::SCP_CMD_LOCK_SET |=> !lock_status[0])
		else $error("lock flag not cleared");
	// Only reset or a good password may raise the flag
	a_lock_rise: assert property ($rose(lock_status[0]) |->
		$past(rst, 2) || $past(go && req.cmd == scp_pkg::SCP_CMD_PASS_OK))
		else $error("lock flag rose without cause");
	a_solid_locked: assert property (go && !lock_status[0] &&
		!opcode_valid && (req.cmd == scp_pkg::SCP_CMD_SET_SOLID ||
		req.cmd == scp_pkg::SCP_CMD_CLR_SOLID) |=> !write_latch_clear)
		else $error("solid change taken while locked");
	a_gang_lock: assert property (
		gang && opcode == `SCP_OP_LOCK_ALL |=> ##1 region_protected)
		else $error("lock-all left region open");
	a_gang_unlock: assert property (
		gang && opcode == `SCP_OP_UNLOCK_ALL && !req.valid ##1
		(!solid_override_bit && protect_scheme_select && !req.valid &&
		!opcode_valid) [*2] |-> !region_protected)
		else $error("unlock-all with mask left region closed");
	a_scheme_off: assert property (!protect_scheme_select |=>
		region_protected && !rd_valid && !write_latch_clear)
		else $error("activity with scheme off");
	c_read: cover property (rd_valid);
	c_write: cover property (write_latch_clear);
	c_open: cover property ($fell(region_protected));
endmodule
bind scp_protect scp_protect_chk scp_protect_chk_inst (.core_clk, .rst,
	.req, .opcode, .opcode_valid, .write_latch, .protect_scheme_select,
	.solid_override_bit, .rd_data, .rd_valid, .region_protected,
	.lock_status, .write_latch_clear);
`default_nettype wire

// [tb/sector_protect_bit_logic_tb.sv]
// Self-checking bench for the protection bit logic
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.svh"
module sector_protect_bit_logic_tb;
	logic core_clk = 0, rst = 1, write_latch_set_cmd = 0, opcode_valid = 0;
	logic protect_scheme_select = 1, solid_override_bit = 1;
	logic [7:0] opcode = 0, rd_data, lock_status;
	logic [1:0] mode_lock_bits = 2'b11;
	logic [17:0] check_addr = 0;
	logic rd_valid, region_protected, write_latch, write_latch_clear;
	scp_pkg::scp_req_s req = '0;
	int fails = 0, n_compared = 0;
	localparam scp_pkg::scp_cmd_e c_rds = scp_pkg::SCP_CMD_RD_SOLID;
	localparam scp_pkg::scp_cmd_e c_rdd = scp_pkg::SCP_CMD_RD_DYN;
	// Clock, then a watchdog far beyond the roughly 70 cycles needed
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#50us;
		fails++;
		end_of_test;
	end
	scp_protect #(.ADDR_W(18)) scp_protect_inst (.core_clk, .rst, .req,
		.opcode, .opcode_valid, .write_latch, .protect_scheme_select,
		.mode_lock_bits, .solid_override_bit, .check_addr, .rd_data,
		.rd_valid, .region_protected, .lock_status, .write_latch_clear);
	scp_host_model scp_host_model_inst (.core_clk, .rst, .write_latch_set_cmd,
		.write_latch_clear, .write_latch);
	// Bus cycles, all driven from the falling edge
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input scp_pkg::scp_cmd_e c, input logic [17:0] a,
		input logic v, input logic we);
		write_latch_set_cmd = we;
		@(negedge core_clk);
		write_latch_set_cmd = 0;
		req = '{1'b1, c, {14'h0, a}, v};
		@(negedge core_clk);
		req.valid = 0;
	endtask
	task automatic rd(input scp_pkg::scp_cmd_e c, input logic [17:0] a,
		input logic [7:0] e);
		cmd(c, a, 1'b0, 1'b0);
		chk({rd_valid, rd_data}, {1'b1, e});
	endtask
	task automatic gang(input logic [7:0] op);
		write_latch_set_cmd = 1;
		@(negedge core_clk);
		write_latch_set_cmd = 0;
		opcode = op;
		opcode_valid = 1;
		@(negedge core_clk);
		opcode_valid = 0;
	endtask
	task automatic pr(input logic [17:0] a, input logic e);
		check_addr = a;
		repeat (2) @(negedge core_clk);
		chk(region_protected, e);
	endtask
	task automatic rs(input logic [1:0] m);
		mode_lock_bits = m;
		rst = 1;
		repeat (4) @(negedge core_clk);
		rst = 0;
		repeat (2) @(negedge core_clk);
	endtask
	task automatic end_of_test;
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		rs(2'b11);
		chk(lock_status, 8'h01);
		rd(scp_pkg::SCP_CMD_RD_LOCK, 0, 8'h01);
		rd(c_rdd, 18'h3f000, 8'hff);
		rd(c_rds, 18'h0, 8'h00);
		cmd(scp_pkg::SCP_CMD_SET_SOLID, 18'h01000, 0, 1);
		rd(c_rds, 18'h01fff, 8'hff);
		rd(c_rds, 18'h00fff, 8'h00);
		rd(c_rds, 18'h11000, 8'h00);
		solid_override_bit = 0;
		gang(`SCP_OP_UNLOCK_ALL);
		pr(18'h01000, 0);
		rd(c_rdd, 18'h3f000, 8'h00);
		solid_override_bit = 1;
		pr(18'h01000, 1);
		pr(18'h00000, 0);
		cmd(scp_pkg::SCP_CMD_WR_DYN, 18'h20000, 1, 1);
		rd(c_rdd, 18'h2ffff, 8'hff);
		rd(c_rdd, 18'h1ffff, 8'h00);
		pr(18'h2abcd, 1);
		cmd(scp_pkg::SCP_CMD_WR_DYN, 18'h20000, 0, 0);
		rd(c_rdd, 18'h20000, 8'hff);
		cmd(scp_pkg::SCP_CMD_CLR_SOLID, 0, 0, 1);
		rd(c_rds, 18'h01000, 8'h00);
		cmd(scp_pkg::SCP_CMD_SET_SOLID, 18'h3f000, 0, 1);
		cmd(scp_pkg::SCP_CMD_LOCK_SET, 0, 0, 1);
		chk(lock_status, 8'h00);
		cmd(scp_pkg::SCP_CMD_CLR_SOLID, 0, 0, 1);
		rd(c_rds, 18'h3ffff, 8'hff);
		gang(`SCP_OP_LOCK_ALL);
		rd(c_rdd, 18'h0, 8'hff);
		protect_scheme_select = 0;
		cmd(c_rdd, 0, 0, 0);
		chk(rd_valid, 0);
		protect_scheme_select = 1;
		rs(2'b01);
		chk(lock_status, 8'h00);
		rd(c_rds, 18'h3f000, 8'hff);
		cmd(scp_pkg::SCP_CMD_PASS_OK, 0, 0, 1);
		chk(lock_status, 8'h01);
		end_of_test;
	end
endmodule
`default_nettype wire
